/* File: design/strap_pin_mux.sv */
// strap_pin_mux: strap-selected routing of cache, dram and peripheral pins
// assumes synchronous inputs; bidirectional pins split into in/out/oe_n
//
// Behaviour
// - address bits 8:7 strapped 00 give second local-bus request and grant.
// - strap 01 gives low and high dram bank selects on shared pins.
// - bit 8 strapped 1 gives isa memory read and turbo-bus-active.
// - two cache output enables, two chip selects, four byte write enables.
// - two banks: each addr select is A3; one bank: A2 and A3.
// - eight-bit bidirectional tag bus and a tag write enable.
// - one row strobe per bank pair; bank selects split double pairs.
// - fourth row strobe pin carries address bit 11 when bank 3 absent.
// - during reset row strobe pins carry clock frequency selects.
// - one column strobe per byte lane and one shared dram write enable.
// - address pins 0-3 carry selects in non-dram cycles, qualified by demux.
// - during reset address pins 0-3 are keyboard controller input ports.
// - pins 4-7 carry peripheral control; pin 8 strobes the external latch.
// - bit 6 strapped high makes parity pins bidirectional dram parity.
// - bit 6 strapped low makes parity pins unqualified selects and strobes.
// - demux control high in dram cycles, low in isa i/o cycles.
`timescale 1ns/1ps
module strap_pin_mux
  import strap_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // core side
  input wire logic dram_cycle,
  input wire logic two_cache_banks,
  input wire logic bank3_absent,
  input wire logic [1:0] cache_addr_bits,
  input wire logic [DRAM_ADDR_W-1:0] core_dram_addr,
  input wire cache_ctl_t core_cache,
  input wire dram_ctl_t core_dram,
  input wire periph_sel_t core_periph,
  input wire logic [3:0] core_periph_ctl,
  input wire logic [3:0] clock_sel_cfg,
  input wire logic [7:0] core_tag_out,
  input wire logic core_tag_drive,
  input wire logic [3:0] core_parity_out,
  input wire logic core_parity_drive,
  input wire logic core_lbus_grant_n,
  input wire logic core_isa_memr_n,
  input wire logic core_turbo_n,
  output logic [7:0] core_tag_in,
  output logic [3:0] core_parity_in,
  output logic core_lbus_request_n,
  output logic [3:0] kbc_in_port,
  output strap_cfg_t strap_cfg,
  // pin side
  input wire logic [DRAM_ADDR_W-1:0] addr_pin_in,
  output logic [DRAM_ADDR_W-1:0] dram_row_col_addr,
  output logic [DRAM_ADDR_W-1:0] addr_pin_oe_n,
  output logic addr_demux_ctl,
  output logic [3:0] row_strobe_n,
  output logic [3:0] col_strobe_n,
  output logic dram_write_n,
  output logic [1:0] cache_out_enable,
  output logic [1:0] cache_chip_select,
  output logic [3:0] cache_byte_write_enable,
  output logic [1:0] cache_addr_sel,
  input wire logic [7:0] tag_data_in,
  output logic [7:0] tag_data_out,
  output logic tag_data_oe_n,
  output logic tag_write_enable,
  input wire logic [1:0] shared_pin_in,
  output logic [1:0] shared_pin_out,
  output logic [1:0] shared_pin_oe_n,
  input wire logic [3:0] mem_parity_in,
  output logic [3:0] mem_parity_out,
  output logic [3:0] mem_parity_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: sampled on the first edge after release, then frozen

  strap_cfg_t cfg_ff, nxt_cfg;
  logic held_ff, nxt_held;
  logic [3:0] kbc_ff, nxt_kbc;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_held = held_ff;
    nxt_kbc = kbc_ff;
    if (!rst_n) begin
      nxt_held = 1'b0;
      nxt_kbc = addr_pin_in[3:0];
    end else if (!held_ff) begin
      nxt_held = 1'b1;
      nxt_cfg.isa_mode = addr_pin_in[STRAP_BANK_HI];
      nxt_cfg.lbus_mode = ({addr_pin_in[STRAP_BANK_HI],
                            addr_pin_in[STRAP_BANK_LO]} == BANK_MODE_LBUS);
      nxt_cfg.bank_mode = ({addr_pin_in[STRAP_BANK_HI],
                            addr_pin_in[STRAP_BANK_LO]} == BANK_MODE_BSEL);
      nxt_cfg.parity_mode = addr_pin_in[STRAP_PARITY];
    end
  end

  // cfg is not reset: it is loaded from the pins at release instead
  always_ff @(posedge clk) begin
    cfg_ff <= nxt_cfg;
    held_ff <= nxt_held;
    kbc_ff <= nxt_kbc;
  end

  assign strap_cfg = cfg_ff;
  assign kbc_in_port = kbc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registered pin outputs

  logic [DRAM_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DRAM_ADDR_W-1:0] addr_oe_ff, nxt_addr_oe;
  logic demux_ff, nxt_demux;
  logic [3:0] ras_ff, nxt_ras;
  logic [1:0] sh_ff, nxt_sh;
  logic [1:0] sh_oe_ff, nxt_sh_oe;
  logic [3:0] par_ff, nxt_par;
  logic [3:0] par_oe_ff, nxt_par_oe;

  always_comb begin
    nxt_addr = core_dram_addr;
    nxt_addr_oe = '0;
    nxt_demux = dram_cycle;
    nxt_ras = core_dram.row_strobe_n;
    nxt_sh = 2'h3;
    nxt_sh_oe = 2'h3;
    nxt_par = 4'hF;
    nxt_par_oe = 4'hF;
    if (!rst_n || !held_ff) begin
      nxt_ras = clock_sel_cfg;
      nxt_addr_oe = ADDR_OE_RESET;
      nxt_demux = 1'b1;
    end else begin
      if (bank3_absent) begin
        nxt_ras[3] = core_dram_addr[11];
      end
      if (!dram_cycle) begin
        nxt_addr[0] = core_periph.boot_rom_n;
        nxt_addr[1] = core_periph.keyboard_n;
        nxt_addr[2] = core_periph.clock_data_n;
        nxt_addr[3] = core_periph.clock_rw_n;
        nxt_addr[7:4] = core_periph_ctl;
        nxt_addr[8] = core_periph.periph_we_n;
      end
      if (cfg_ff.lbus_mode) begin
        nxt_sh[1] = core_lbus_grant_n;
        nxt_sh_oe = 2'h1;
      end else if (cfg_ff.bank_mode) begin
        nxt_sh = {core_dram.high_bank_n, core_dram.low_bank_n};
        nxt_sh_oe = 2'h0;
      end else begin
        nxt_sh = {core_turbo_n, core_isa_memr_n};
        nxt_sh_oe = 2'h0;
      end
      if (cfg_ff.parity_mode) begin
        nxt_par = core_parity_out;
        nxt_par_oe = {4{~core_parity_drive}};
      end else begin
        nxt_par = {core_periph.drive_write_n, core_periph.drive_read_n,
                   core_periph.keyboard_n, core_periph.clock_data_n};
        nxt_par_oe = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_ff <= '0;
      addr_oe_ff <= ADDR_OE_RESET;
      demux_ff <= 1'b1;
      ras_ff <= clock_sel_cfg;
      sh_ff <= 2'h3;
      sh_oe_ff <= 2'h3;
      par_ff <= 4'hF;
      par_oe_ff <= 4'hF;
    end else begin
      addr_ff <= nxt_addr;
      addr_oe_ff <= nxt_addr_oe;
      demux_ff <= nxt_demux;
      ras_ff <= nxt_ras;
      sh_ff <= nxt_sh;
      sh_oe_ff <= nxt_sh_oe;
      par_ff <= nxt_par;
      par_oe_ff <= nxt_par_oe;
    end
  end

  assign dram_row_col_addr = addr_ff;
  assign addr_pin_oe_n = addr_oe_ff;
  assign addr_demux_ctl = demux_ff;
  assign row_strobe_n = ras_ff;
  assign shared_pin_out = sh_ff;
  assign shared_pin_oe_n = sh_oe_ff;
  assign mem_parity_out = par_ff;
  assign mem_parity_oe_n = par_oe_ff;
  assign core_lbus_request_n = cfg_ff.lbus_mode ? shared_pin_in[0] : 1'b1;
  assign core_parity_in = mem_parity_in;

  ////////////////////////////////////////////////////////////////////////////
  // cache and dram strobes registered straight through; cache address selects pass the bank-count mux

  cache_ctl_t cache_ff;
  logic [1:0] asel_ff, nxt_asel;
  logic [3:0] cas_ff;
  logic dwe_ff;
  logic [7:0] tag_ff;
  logic tag_oe_ff;

  always_comb begin
    if (two_cache_banks) begin
      nxt_asel = {2{cache_addr_bits[1]}};
    end else begin
      nxt_asel = cache_addr_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cache_ff <= '1;
      asel_ff <= '0;
      cas_ff <= 4'hF;
      dwe_ff <= 1'b1;
      tag_ff <= '0;
      tag_oe_ff <= 1'b1;
    end else begin
      cache_ff <= core_cache;
      asel_ff <= nxt_asel;
      cas_ff <= core_dram.col_strobe_n;
      dwe_ff <= core_dram.write_n;
      tag_ff <= core_tag_out;
      tag_oe_ff <= ~core_tag_drive;
    end
  end

  assign cache_out_enable = cache_ff.out_enable_n;
  assign cache_chip_select = cache_ff.chip_select_n;
  assign cache_byte_write_enable = cache_ff.byte_write_n;
  assign cache_addr_sel = asel_ff;
  assign tag_write_enable = cache_ff.tag_write_n;
  assign tag_data_out = tag_ff;
  assign tag_data_oe_n = tag_oe_ff;
  assign core_tag_in = tag_data_in;
  assign col_strobe_n = cas_ff;
  assign dram_write_n = dwe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence strap_release_s;
    !held_ff && rst_n;
  endsequence

  strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && $past(held_ff) |-> $stable(cfg_ff))
    else $error("strap config changed after capture");

  lbus_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    strap_release_s ##1 cfg_ff.lbus_mode |-> ##1 shared_pin_oe_n == 2'h1)
    else $error("local-bus pins mis-driven");

  bank_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && cfg_ff.bank_mode |=> shared_pin_out ==
      $past({core_dram.high_bank_n, core_dram.low_bank_n}))
    else $error("bank selects not routed");

  isa_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && cfg_ff.isa_mode |=> shared_pin_out[0] ==
      $past(core_isa_memr_n))
    else $error("isa memory read not routed");

  clksel_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !held_ff |=> row_strobe_n == $past(clock_sel_cfg))
    else $error("clock select not shown during reset");

  demux_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && !dram_cycle |=> !addr_demux_ctl)
    else $error("demux control high outside dram cycle");

  periph_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && !dram_cycle |=> dram_row_col_addr[7:4] ==
      $past(core_periph_ctl))
    else $error("peripheral control not on address pins");

  parity_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && !cfg_ff.parity_mode |=> mem_parity_oe_n == 4'h0)
    else $error("parity pins not driven as selects");

  asel_a: assert property (@(posedge clk) disable iff (!rst_n)
    two_cache_banks |=> cache_addr_sel[0] == cache_addr_sel[1])
    else $error("interleave selects differ");

  kbc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff |-> $stable(kbc_in_port))
    else $error("keyboard ports moved outside reset");

  row_addr11_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && bank3_absent |=> row_strobe_n[3] ==
      $past(core_dram_addr[11]))
    else $error("address bit 11 not on fourth row strobe");

  parity_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    held_ff && cfg_ff.parity_mode |=> mem_parity_oe_n ==
      {4{!$past(core_parity_drive)}})
    else $error("parity pins drive state wrong");

endmodule : strap_pin_mux

/* File: design/strap_mux_pkg.sv */
// strap_mux_pkg: shared types and constants for the strap pin multiplexer
// assumes one clock domain and a synchronous active-low reset
package strap_mux_pkg;

  localparam int DRAM_ADDR_W = 12;
  localparam int STRAP_BANK_HI = 8;
  localparam int STRAP_BANK_LO = 7;
  localparam int STRAP_PARITY = 6;
  localparam logic [1:0] BANK_MODE_LBUS = 2'h0;
  localparam logic [1:0] BANK_MODE_BSEL = 2'h1;
  localparam logic [3:0] CLKSEL_RESET = 4'h0;
  // reset lets go of strap pins 8:6 and keyboard ports 3:0 so pulls are read
  localparam logic [DRAM_ADDR_W-1:0] ADDR_OE_RESET = 12'h1CF;

  // core-side strobes that the pin mux routes out, all except addr_sel
  typedef struct packed {
    logic [1:0] out_enable_n;
    logic [1:0] chip_select_n;
    logic [3:0] byte_write_n;
    logic [1:0] addr_sel;
    logic tag_write_n;
  } cache_ctl_t;

  typedef struct packed {
    logic [3:0] row_strobe_n;
    logic [3:0] col_strobe_n;
    logic write_n;
    logic low_bank_n;
    logic high_bank_n;
  } dram_ctl_t;

  // peripheral selects requested by the core, active low
  typedef struct packed {
    logic boot_rom_n;
    logic keyboard_n;
    logic clock_data_n;
    logic clock_rw_n;
    logic periph_we_n;
    logic drive_read_n;
    logic drive_write_n;
  } periph_sel_t;

  typedef struct packed {
    logic lbus_mode;
    logic bank_mode;
    logic isa_mode;
    logic parity_mode;
  } strap_cfg_t;

endpackage : strap_mux_pkg

/* File: tb/far_side_model.sv */
// far_side_model: strap pulls and far-side drivers on the shared pins
// assumes a released pin shows whatever the far side presents on it
`timescale 1ns/1ps
module far_side_model (
  input wire logic [11:0] pull_val,
  input wire logic [7:0] tag_val,
  input wire logic [3:0] par_val,
  input wire logic req_n,
  input wire logic [11:0] dram_row_col_addr,
  input wire logic [11:0] addr_pin_oe_n,
  input wire logic [7:0] tag_data_out,
  input wire logic tag_data_oe_n,
  input wire logic [1:0] shared_pin_out,
  input wire logic [1:0] shared_pin_oe_n,
  input wire logic [3:0] mem_parity_out,
  input wire logic [3:0] mem_parity_oe_n,
  output logic [11:0] addr_pin_in,
  output logic [7:0] tag_data_in,
  output logic [1:0] shared_pin_in,
  output logic [3:0] mem_parity_in
);
  // straps and keyboard port levels appear only where the device lets go
  assign addr_pin_in = (addr_pin_oe_n & pull_val)
    | (~addr_pin_oe_n & dram_row_col_addr);
  assign tag_data_in = tag_data_oe_n ? tag_val : tag_data_out;
  assign mem_parity_in = (mem_parity_oe_n & par_val)
    | (~mem_parity_oe_n & mem_parity_out);
  // an undriven pin 1 floats to the inverse so stale values never pass
  assign shared_pin_in[1] = shared_pin_oe_n[1] ? ~shared_pin_out[1]
    : shared_pin_out[1];
  assign shared_pin_in[0] = shared_pin_oe_n[0] ? req_n
    : shared_pin_out[0];
endmodule : far_side_model

/* File: tb/strap_pin_mux_cache_dram_tb.sv */
// strap_pin_mux_cache_dram_tb: strap corners plus random core traffic
// assumes a 100 MHz clock and the far-side model resolving released pins
`timescale 1ns/1ps
module strap_pin_mux_cache_dram_tb;
  import strap_mux_pkg::*;
  logic clk, rst_n, dram_cycle, two_cache_banks, bank3_absent, req_n;
  logic core_tag_drive, core_parity_drive, core_lbus_grant_n;
  logic core_isa_memr_n, core_turbo_n, core_lbus_request_n, addr_demux_ctl;
  logic dram_write_n, tag_data_oe_n, tag_write_enable;
  logic [1:0] cache_addr_bits, cache_out_enable, cache_chip_select;
  logic [1:0] cache_addr_sel, shared_pin_in, shared_pin_out, shared_pin_oe_n;
  logic [3:0] core_periph_ctl, clock_sel_cfg, core_parity_out, par_val;
  logic [3:0] core_parity_in, kbc_in_port, row_strobe_n, col_strobe_n;
  logic [3:0] cache_byte_write_enable, mem_parity_in, mem_parity_out;
  logic [3:0] mem_parity_oe_n;
  logic [7:0] core_tag_out, tag_val, core_tag_in, tag_data_in, tag_data_out;
  logic [DRAM_ADDR_W-1:0] core_dram_addr, pull_val, addr_pin_in;
  logic [DRAM_ADDR_W-1:0] dram_row_col_addr, addr_pin_oe_n;
  logic [11:0] tbl [4] = '{12'h000, 12'h0C0, 12'h100, 12'h1C0};
  cache_ctl_t core_cache;
  dram_ctl_t core_dram;
  periph_sel_t core_periph;
  strap_cfg_t strap_cfg, ecfg;
  int error_cnt = 0;
  int cmp_count = 0;

  strap_pin_mux dut (
    .clk(clk), .rst_n(rst_n), .dram_cycle(dram_cycle),
    .two_cache_banks(two_cache_banks), .bank3_absent(bank3_absent),
    .cache_addr_bits(cache_addr_bits), .core_dram_addr(core_dram_addr),
    .core_cache(core_cache), .core_dram(core_dram),
    .core_periph(core_periph), .core_periph_ctl(core_periph_ctl),
    .clock_sel_cfg(clock_sel_cfg), .core_tag_out(core_tag_out),
    .core_tag_drive(core_tag_drive), .core_parity_out(core_parity_out),
    .core_parity_drive(core_parity_drive),
    .core_lbus_grant_n(core_lbus_grant_n),
    .core_isa_memr_n(core_isa_memr_n), .core_turbo_n(core_turbo_n),
    .core_tag_in(core_tag_in), .core_parity_in(core_parity_in),
    .core_lbus_request_n(core_lbus_request_n), .kbc_in_port(kbc_in_port),
    .strap_cfg(strap_cfg), .addr_pin_in(addr_pin_in),
    .dram_row_col_addr(dram_row_col_addr), .addr_pin_oe_n(addr_pin_oe_n),
    .addr_demux_ctl(addr_demux_ctl), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .dram_write_n(dram_write_n),
    .cache_out_enable(cache_out_enable),
    .cache_chip_select(cache_chip_select),
    .cache_byte_write_enable(cache_byte_write_enable),
    .cache_addr_sel(cache_addr_sel), .tag_data_in(tag_data_in),
    .tag_data_out(tag_data_out), .tag_data_oe_n(tag_data_oe_n),
    .tag_write_enable(tag_write_enable), .shared_pin_in(shared_pin_in),
    .shared_pin_out(shared_pin_out), .shared_pin_oe_n(shared_pin_oe_n),
    .mem_parity_in(mem_parity_in), .mem_parity_out(mem_parity_out),
    .mem_parity_oe_n(mem_parity_oe_n)
  );
  far_side_model far (
    .pull_val(pull_val), .tag_val(tag_val), .par_val(par_val),
    .req_n(req_n), .dram_row_col_addr(dram_row_col_addr),
    .addr_pin_oe_n(addr_pin_oe_n), .tag_data_out(tag_data_out),
    .tag_data_oe_n(tag_data_oe_n), .shared_pin_out(shared_pin_out),
    .shared_pin_oe_n(shared_pin_oe_n), .mem_parity_out(mem_parity_out),
    .mem_parity_oe_n(mem_parity_oe_n), .addr_pin_in(addr_pin_in),
    .tag_data_in(tag_data_in), .shared_pin_in(shared_pin_in),
    .mem_parity_in(mem_parity_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apply(logic [63:0] r, logic [63:0] s);
    {dram_cycle, two_cache_banks, bank3_absent, cache_addr_bits,
     core_dram_addr, core_cache, core_dram, core_periph} = r[45:0];
    {core_periph_ctl, core_tag_out, core_tag_drive, core_parity_out,
     core_parity_drive, core_lbus_grant_n, core_isa_memr_n, core_turbo_n,
     tag_val, par_val, req_n} = s[33:0];
    // pull levels keep moving so late strap changes are exercised
    pull_val = s[45:34];
  endtask : apply

  function automatic logic [3:0] exp_shared();
    if (ecfg.lbus_mode) return {2'b01, core_lbus_grant_n, 1'b0};
    if (ecfg.bank_mode)
      return {2'b00, core_dram.high_bank_n, core_dram.low_bank_n};
    return {2'b00, core_turbo_n, core_isa_memr_n};
  endfunction : exp_shared

  function automatic logic [7:0] exp_parity();
    if (ecfg.parity_mode)
      return {{4{~core_parity_drive}}, core_parity_out};
    return {4'h0, core_periph.drive_write_n, core_periph.drive_read_n,
      core_periph.keyboard_n, core_periph.clock_data_n};
  endfunction : exp_parity

////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(logic [11:0] sv);
    logic [3:0] k;
    k = 4'($urandom);
    pull_val = {sv[11:4], k};
    clock_sel_cfg = 4'($urandom);
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("clksel", 12'(clock_sel_cfg), 12'(row_strobe_n));
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    ecfg = '{sv[8:7] == 2'b00, sv[8:7] == 2'b01, sv[8], sv[6]};
    chk("kbc", 12'(k), 12'(kbc_in_port));
    chk("strap", 12'(ecfg), 12'(strap_cfg));
  endtask : do_reset

  task automatic check_cycle();
    logic [11:0] a;
    a = {3'h0, core_periph.periph_we_n, core_periph_ctl,
      core_periph.clock_rw_n, core_periph.clock_data_n,
      core_periph.keyboard_n, core_periph.boot_rom_n};
    chk("held", 12'(ecfg), 12'(strap_cfg));
    chk("demux", 12'(dram_cycle), 12'(addr_demux_ctl));
    chk("addr oe", 12'h0, {3'h0, addr_pin_oe_n[8:0]});
    if (dram_cycle) chk("addr", core_dram_addr, dram_row_col_addr);
    else chk("sel", a, {3'h0, dram_row_col_addr[8:0]});
    chk("cache", 12'({core_cache.out_enable_n, core_cache.chip_select_n,
      core_cache.byte_write_n}), 12'({cache_out_enable, cache_chip_select,
      cache_byte_write_enable}));
    chk("asel", 12'(two_cache_banks ? {2{cache_addr_bits[1]}}
      : cache_addr_bits), 12'(cache_addr_sel));
    chk("tag", 12'({core_tag_out, ~core_tag_drive, core_cache.tag_write_n}),
      12'({tag_data_out, tag_data_oe_n, tag_write_enable}));
    chk("row", 12'({bank3_absent ? core_dram_addr[11]
      : core_dram.row_strobe_n[3], core_dram.row_strobe_n[2:0]}),
      12'(row_strobe_n));
    chk("col", 12'({core_dram.col_strobe_n, core_dram.write_n}),
      12'({col_strobe_n, dram_write_n}));
    chk("shared", 12'(exp_shared()), 12'({shared_pin_oe_n, shared_pin_out[1],
      shared_pin_out[0] & ~ecfg.lbus_mode}));
    chk("parity", 12'(exp_parity()),
      12'({mem_parity_oe_n, mem_parity_out}));
    chk("request", 12'(ecfg.lbus_mode ? req_n : 1'b1),
      12'(core_lbus_request_n));
    if (tag_data_oe_n === 1'b1)
      chk("tag in", 12'(tag_val), 12'(core_tag_in));
    if (ecfg.parity_mode && mem_parity_oe_n === 4'hF)
      chk("par in", 12'(par_val), 12'(core_parity_in));
  endtask : check_cycle

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(45));
    apply(64'h0, 64'h0);
    // all four settings of strap bits 8:7, each preceded by its own reset
    for (int i = 0; i < 4; i++) begin
      do_reset((12'($urandom) & 12'hE30) | tbl[i]);
      repeat (150) begin
        apply({$urandom, $urandom}, {$urandom, $urandom});
        @(posedge clk);
        #1;
        check_cycle();
      end
    end
    test_done();
  end
endmodule : strap_pin_mux_cache_dram_tb
